/* File: hdl/rut_defs.svh */
// Purpose: Constants for the upgrade trigger link between factory user logic and upgrade circuitry
// Assumes: 40 MHz clock
// Notes: Operation codes and timing counts
`ifndef RUT_DEFS_SVH
`define RUT_DEFS_SVH
`define RUT_OP_START_ADDR 3'h4
`define RUT_APP_ADDR 24'h650000
`define RUT_CLK_NS 25
`define RUT_RELOAD_MIN_NS 250
`define RUT_RELOAD_CYC ((`RUT_RELOAD_MIN_NS + `RUT_CLK_NS - 1) / `RUT_CLK_NS)
`define RUT_WR_CYC 4'h3
`define RUT_CHK_CYC 8'h10
`endif

/* File: hdl/rut_factory_user.sv */
// Purpose: Factory image user logic: writes start address then requests reload
// Assumes: Device end follows busy protocol
// Notes: Reports load failure on image fault
`include "rut_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module rut_factory_user
    import rut_pkg::*;
#(
    parameter logic [23:0] APP_ADDR = `RUT_APP_ADDR
)
(
    input wire logic clk, // System clock
    input wire logic sys_rst, // Synchronous reset
    rut_link_if.usr lnk, // Link to device
    input wire logic start, // Begin upgrade sequence
    output logic app_load_fail, // Image load failure status
    output logic seq_done // Reload request issued
);
    typedef enum logic [2:0] {UF_IDLE = 3'b000, UF_WR = 3'b001, UF_WAIT = 3'b011, UF_HOLD = 3'b010,
        UF_END = 3'b110} uf_st_e;
    uf_st_e st, next_st;
    logic [7:0] cnt, next_cnt;
    logic strobe, next_strobe, reload, next_reload, fail, next_fail, done, next_done;
    logic busy_seen, next_busy_seen;

    // Sequence: address write, wait idle, reload pulse
    always_comb
    begin
        next_st = st;
        next_cnt = cnt;
        next_strobe = 1'b0;
        next_reload = reload;
        next_fail = fail | lnk.image_fault;
        next_done = done;
        next_busy_seen = busy_seen;
        case (st)
            UF_IDLE:
                if (start && !lnk.busy)
                begin
                    next_strobe = 1'b1;
                    next_busy_seen = 1'b0;
                    next_st = UF_WR;
                end
            UF_WR:
                next_st = UF_WAIT;
            UF_WAIT:
            begin
                // Only proceed after write busy has come and gone
                if (lnk.busy)
                    next_busy_seen = 1'b1;
                else if (busy_seen)
                begin
                    next_reload = 1'b1;
                    next_cnt = 8'(`RUT_RELOAD_CYC);
                    next_st = UF_HOLD;
                end
            end
            UF_HOLD:
                if (cnt == 8'h1)
                begin
                    next_reload = 1'b0;
                    next_done = 1'b1;
                    next_st = UF_END;
                end
                else
                    next_cnt = cnt - 8'h1;
            UF_END:
                next_st = UF_END;
            default:
                next_st = UF_IDLE;
        endcase
    end

    // Registers
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            st <= UF_IDLE;
            cnt <= 8'h0;
            strobe <= 1'b0;
            reload <= 1'b0;
            fail <= 1'b0;
            done <= 1'b0;
            busy_seen <= 1'b0;
        end
        else
        begin
            st <= next_st;
            cnt <= next_cnt;
            strobe <= next_strobe;
            reload <= next_reload;
            fail <= next_fail;
            done <= next_done;
            busy_seen <= next_busy_seen;
        end
    end

    // Op and value held constant for the whole sequence
    assign lnk.op = `RUT_OP_START_ADDR;
    assign lnk.wr_value = APP_ADDR;
    assign lnk.wr_strobe = strobe;
    assign lnk.reload_req = reload;
    assign app_load_fail = fail;
    assign seq_done = done;
endmodule
`default_nettype wire

/* File: hdl/rut_link_if.sv */
// Purpose: Link between user logic and upgrade circuitry
// Assumes: One clock
// Notes: No clocking block
`timescale 1ns/1ps
`default_nettype none
interface rut_link_if (input wire logic clk);
    rut_pkg::rut_op_t op;
    rut_pkg::rut_val_t wr_value;
    logic wr_strobe;
    logic reload_req;
    logic busy;
    logic image_fault;
    modport dev (input clk, op, wr_value, wr_strobe, reload_req, output busy, image_fault);
    modport usr (input clk, busy, image_fault, output op, wr_value, wr_strobe, reload_req);
endinterface
`default_nettype wire

/* File: hdl/rut_pkg.sv */
// Purpose: Shared types for the upgrade trigger link
// Assumes: Included defines
// Notes: Types only
package rut_pkg;
    typedef logic [2:0] rut_op_t;
    typedef logic [23:0] rut_val_t;
endpackage

/* File: hdl/rut_upgrade_dev.sv */
// Purpose: Upgrade circuitry end: stores start address, prechecks image, triggers reload
// Assumes: User logic keeps inputs stable while busy
// Notes: The flash frame read is abstracted: flash_rd starts it, frame_valid returns the verdict
//        Requests that arrive while busy are dropped with no indication to the user side
//        After a restart pulse this end stays put until reset, as the device is reconfiguring
// Functional notes
// - User writes start address before reload
// - Address write uses op 100 and strobe
// - Busy rises on accepted write, falls after
// - Stored address is flash start unchanged
// - Reload request held high at least 250ns
// - Reload acts like config restart pin
// - Precheck holds busy, reads first frame
// - Valid image triggers application load
// - Invalid image raises fault, factory stays
// - User reports load failure on fault
`include "rut_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module rut_upgrade_dev
    import rut_pkg::*;
(
    input wire logic clk, // System clock
    input wire logic sys_rst, // Synchronous reset
    rut_link_if.dev lnk, // Link to user logic
    input wire logic precheck_en, // Image precheck option
    input wire logic frame_valid, // First frame check result from flash reader
    output logic [23:0] boot_addr, // Flash byte address of application image
    output logic flash_rd, // Request first frame read at boot_addr
    output logic config_restart_pin, // Reconfigure pulse to config logic
    output logic busy_q, // Mirror of busy
    output logic fault_q // Mirror of image fault
);
    typedef enum logic [1:0] {RUT_IDLE = 2'b00, RUT_WR = 2'b01, RUT_CHK = 2'b11, RUT_DONE = 2'b10} rut_st_e;
    rut_st_e st, next_st;
    logic [7:0] cnt, next_cnt;
    logic [23:0] next_addr;
    logic next_busy, next_fault, next_restart, next_rd;
    logic req_d, next_req_d;
    logic reload_edge;
    logic frame_s1, frame_s2, frame_s3, frame_ok;
    logic next_frame_ok;

    // One step of the shared down-counter used by write and check timing
    function automatic logic [7:0] cnt_step(input logic [7:0] cur);
    begin
        return cur - 8'h1;
    end
    endfunction

    // End of a write or check delay
    function automatic logic cnt_zero(input logic [7:0] cur);
    begin
        return cur == 8'h0;
    end
    endfunction

    // Only the start address operation stores its value
    function automatic logic is_addr_op(input rut_op_t code);
    begin
        return code == `RUT_OP_START_ADDR;
    end
    endfunction

    // Reload request edge; a request still held high must not retrigger from idle
    always_comb
    begin
        next_req_d = lnk.reload_req;
        reload_edge = lnk.reload_req && !req_d;
    end

    // Previous reload request level
    always_ff @(posedge clk)
    begin
        if (sys_rst)
            req_d <= 1'b0;
        else
            req_d <= next_req_d;
    end

    // Frame verdict filter: the flash side is not timed to this clock, so the
    // result only moves once the last two synchroniser stages agree
    always_comb
    begin
        next_frame_ok = frame_ok;
        if (frame_s2 == frame_s3)
            next_frame_ok = frame_s3;
    end

    // Synchroniser stages and filtered frame verdict
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            frame_s1 <= 1'b0;
            frame_s2 <= 1'b0;
            frame_s3 <= 1'b0;
            frame_ok <= 1'b0;
        end
        else
        begin
            frame_s1 <= frame_valid;
            frame_s2 <= frame_s1;
            frame_s3 <= frame_s2;
            frame_ok <= next_frame_ok;
        end
    end

    // Next-state logic for write and reload handling
    always_comb
    begin
        next_st = st;
        next_cnt = cnt;
        next_addr = boot_addr;
        next_busy = busy_q;
        next_fault = fault_q;
        next_restart = 1'b0;
        next_rd = 1'b0;
        case (st)
            RUT_IDLE:
            begin
                if (lnk.wr_strobe)
                begin
                    if (is_addr_op(lnk.op))
                        next_addr = lnk.wr_value;
                    next_busy = 1'b1;
                    next_cnt = {4'h0, `RUT_WR_CYC};
                    next_st = RUT_WR;
                end
                else if (reload_edge)
                begin
                    if (precheck_en)
                    begin
                        next_busy = 1'b1;
                        next_rd = 1'b1;
                        next_cnt = `RUT_CHK_CYC;
                        next_st = RUT_CHK;
                    end
                    else
                    begin
                        next_restart = 1'b1;
                        next_st = RUT_DONE;
                    end
                end
            end
            RUT_WR:
            begin
                // Write completion is a fixed internal delay
                if (cnt_zero(cnt))
                begin
                    next_busy = 1'b0;
                    next_st = RUT_IDLE;
                end
                else
                    next_cnt = cnt_step(cnt);
            end
            RUT_CHK:
            begin
                // Frame result sampled once the read delay expires
                if (cnt_zero(cnt))
                begin
                    next_busy = 1'b0;
                    if (frame_ok)
                    begin
                        next_restart = 1'b1;
                        next_st = RUT_DONE;
                    end
                    else
                    begin
                        next_fault = 1'b1;
                        next_st = RUT_IDLE;
                    end
                end
                else
                    next_cnt = cnt_step(cnt);
            end
            RUT_DONE:
                // Device is reconfiguring; remain until reset
                next_st = RUT_DONE;
            default:
                next_st = RUT_IDLE;
        endcase
    end

    // Registers
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            st <= RUT_IDLE;
            cnt <= 8'h0;
            boot_addr <= 24'h0;
            busy_q <= 1'b0;
            fault_q <= 1'b0;
            config_restart_pin <= 1'b0;
            flash_rd <= 1'b0;
        end
        else
        begin
            st <= next_st;
            cnt <= next_cnt;
            boot_addr <= next_addr;
            busy_q <= next_busy;
            fault_q <= next_fault;
            config_restart_pin <= next_restart;
            flash_rd <= next_rd;
        end
    end

    assign lnk.busy = busy_q;
    assign lnk.image_fault = fault_q;
endmodule
`default_nettype wire

/* File: verification/remote_upgrade_reconfig_trigger_tb.sv */
// Purpose: Bench for both link ends joined
// Assumes: 40 MHz clock, synchronous reset
// Notes: Corner reload cases then random ones, random start delay
`include "rut_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module remote_upgrade_reconfig_trigger_tb;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic precheck_en = 1'b0;
    logic frame_valid = 1'b0;
    logic start = 1'b0;
    logic [23:0] boot_addr;
    logic flash_rd, restart, fail, done;
    logic [7:0] n_rd, n_rs, n_bz;
    logic busy_q, fault_q;
    int bad_count = 0;
    int checks_done = 0;
    int cyc = 0;
    rut_link_if lnk (.clk(clk));
    rut_upgrade_dev rut_upgrade_dev_i (.clk(clk), .sys_rst(sys_rst), .lnk(lnk), .precheck_en(precheck_en),
        .frame_valid(frame_valid), .boot_addr(boot_addr), .flash_rd(flash_rd), .config_restart_pin(restart),
        .busy_q(busy_q), .fault_q(fault_q));
    rut_factory_user rut_factory_user_i (.clk(clk), .sys_rst(sys_rst), .lnk(lnk), .start(start),
        .app_load_fail(fail), .seq_done(done));
    rut_link_asserts #(.APP_ADDR(`RUT_APP_ADDR)) rut_link_asserts_i (.clk(clk), .sys_rst(sys_rst), .op(lnk.op),
        .wr_value(lnk.wr_value), .wr_strobe(lnk.wr_strobe), .reload_req(lnk.reload_req), .busy(lnk.busy),
        .image_fault(lnk.image_fault));
    initial
    begin
        forever #12.5 clk = ~clk;
    end
    // Cut a hang short; each case needs well under 100 cycles
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            bad_count++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        if (bad_count == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1)
        begin
            bad_count++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask
    // Application load goes ahead unless a precheck finds no image
    function automatic logic exp_load(input logic pre, input logic ok);
        return !pre || ok;
    endfunction
    // Busy spans the write delay, plus the check delay when precheck is on
    function automatic logic [7:0] exp_busy(input logic pre);
        return 8'(`RUT_WR_CYC) + 8'h01 + (pre ? `RUT_CHK_CYC + 8'h01 : 8'h00);
    endfunction
    // Reset, start after a random delay, count pulses, then judge the outcome
    task automatic run_case(input logic pre, input logic ok);
        sys_rst = 1'b1;
        precheck_en = pre;
        frame_valid = ok;
        start = 1'b0;
        repeat (8) @(posedge clk);
        #2 sys_rst = 1'b0;
        repeat ($urandom_range(1, 6)) @(posedge clk);
        #2 start = 1'b1;
        n_rd = 8'h00;
        n_rs = 8'h00;
        n_bz = 8'h00;
        repeat (60)
        begin
            @(posedge clk);
            #2;
            n_rd = n_rd + 8'(flash_rd);
            n_rs = n_rs + 8'(restart);
            n_bz = n_bz + 8'(busy_q);
        end
        chk(n_bz === exp_busy(pre), "busy cycles");
        chk(fault_q === !exp_load(pre, ok), "fault mirror");
        chk(boot_addr === `RUT_APP_ADDR, "start address");
        chk(n_rs === {7'h00, exp_load(pre, ok)}, "restart pulses");
        chk(n_rd === {7'h00, pre}, "frame reads");
        chk(lnk.image_fault === !exp_load(pre, ok), "image fault");
        chk(fail === !exp_load(pre, ok), "load failure flag");
        chk(done === 1'b1, "sequence end");
    endtask
    initial
    begin
        void'($urandom(42412));
        run_case(1'b0, 1'b0);
        run_case(1'b1, 1'b1);
        run_case(1'b1, 1'b0);
        repeat (4) run_case(1'($urandom), 1'($urandom));
        end_of_test();
    end
endmodule
`default_nettype wire

/* File: verification/rut_link_asserts.sv */
// Purpose: Protocol checks on the upgrade trigger link
// Assumes: One clock, synchronous active-high reset
// Notes: Precheck use is inferred from busy, since only link signals are seen
`timescale 1ns/1ps
`default_nettype none
module rut_link_asserts
    import rut_pkg::*;
#(
    parameter logic [23:0] APP_ADDR = 24'h650000
)
(
    input wire logic clk, // System clock
    input wire logic sys_rst, // Synchronous reset
    input wire rut_pkg::rut_op_t op, // Operation code
    input wire rut_pkg::rut_val_t wr_value, // Write value
    input wire logic wr_strobe, // Write strobe
    input wire logic reload_req, // Reload request
    input wire logic busy, // Device busy
    input wire logic image_fault // Image check fault
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    logic addr_seen;
    logic next_addr_seen;
    // Remember an address write so a later reload can be judged
    always_comb
    begin
        next_addr_seen = addr_seen | (wr_strobe & (op == 3'h4));
    end
    always_ff @(posedge clk)
    begin
        addr_seen <= sys_rst ? 1'b0 : next_addr_seen;
    end
    property p_wr_fields;
        wr_strobe |-> op == 3'h4 && wr_value == APP_ADDR;
    endproperty
    a_wr_fields: assert property (p_wr_fields) else $error("bad write fields");
    property p_busy_on_wr;
        !busy && wr_strobe |=> busy;
    endproperty
    a_busy_on_wr: assert property (p_busy_on_wr) else $error("busy missing after write");
    property p_wr_len;
        $rose(busy) && $past(wr_strobe) |-> busy[*4] ##1 !busy;
    endproperty
    a_wr_len: assert property (p_wr_len) else $error("write busy length");
    property p_addr_first;
        $rose(reload_req) |-> addr_seen;
    endproperty
    a_addr_first: assert property (p_addr_first) else $error("reload before address");
    property p_reload_len;
        $rose(reload_req) |-> reload_req[*5] ##1 reload_req[*5];
    endproperty
    a_reload_len: assert property (p_reload_len) else $error("reload too short");
    property p_check_len;
        $rose(busy) && !$past(wr_strobe) |-> busy[*8] ##1 busy[*8] ##1 busy ##1 !busy;
    endproperty
    a_check_len: assert property (p_check_len) else $error("precheck busy length");
    property p_quiet_busy;
        busy |-> !wr_strobe && !$rose(reload_req);
    endproperty
    a_quiet_busy: assert property (p_quiet_busy) else $error("request while busy");
    property p_hold_busy;
        busy |-> $stable(op) && $stable(wr_value);
    endproperty
    a_hold_busy: assert property (p_hold_busy) else $error("inputs moved while busy");
    property p_fault_end;
        $rose(image_fault) |-> $past(busy) || $past(busy, 2);
    endproperty
    a_fault_end: assert property (p_fault_end) else $error("fault outside check");
    property p_fault_keep;
        image_fault |=> image_fault;
    endproperty
    a_fault_keep: assert property (p_fault_keep) else $error("fault dropped");
endmodule
`default_nettype wire
